/* rtl/mst_pkg.sv */
// Package of constants and types for the modem sync and tuning register bank.
`default_nettype none
package mst_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [6:0] IDX_ZERO_AVG_CONTROL     = 7'h46;
  localparam logic [6:0] IDX_SYNC_DETECT_CONTROL  = 7'h47;
  localparam logic [6:0] IDX_CARRIER_OFFSET       = 7'h48;
  localparam logic [6:0] IDX_OBSERVER_PHASE       = 7'h5b;
  localparam logic [6:0] IDX_UNUSED_SLOT          = 7'h62;

  // Reset values of the control registers.
  localparam logic [7:0] RST_ZERO_AVG_CONTROL     = 8'h40;
  localparam logic [7:0] RST_SYNC_DETECT_CONTROL  = 8'h2e;
  localparam logic [7:0] RST_CARRIER_OFFSET       = 8'h00;
  localparam logic [7:0] RST_OBSERVER_PHASE       = 8'h08;

  // Writable bit masks; all other bits read as zero.
  localparam logic [7:0] MSK_ZERO_AVG_CONTROL     = 8'he0;
  localparam logic [7:0] MSK_SYNC_DETECT_CONTROL  = 8'h3f;
  localparam logic [7:0] MSK_OBSERVER_PHASE       = 8'h0f;

  // Field positions.
  localparam int POS_ZERO_COUNT    = 6;
  localparam int POS_AVG_POLICY    = 5;
  localparam int POS_SFD_STRICT    = 5;
  localparam int POS_CORRELATOR_THRESHOLD      = 0;
  localparam int POS_OBSERVER_EN   = 2;
  localparam int POS_PHASE_REV     = 1;

  // Plain tuning and test registers: receive chain, synthesizer, oscillator calibration a-c,
  // gain loop a-b, low noise amp, gain filter, converter in a-c, demod, converter out a-b,
  // analog probe, converter out c, powerdown a-b, rom and ram self tests.
  localparam int NUM_TUNE = 23;
  localparam logic [6:0] TUNE_IDX [NUM_TUNE] = '{
    7'h4a, 7'h4c, 7'h4e, 7'h4f, 7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57,
    7'h58, 7'h5a, 7'h5c, 7'h5d, 7'h5e, 7'h5f, 7'h60, 7'h61, 7'h7a, 7'h7c, 7'h7e};
  localparam logic [7:0] TUNE_RST [NUM_TUNE] = '{
    8'h29, 8'h55, 8'h24, 8'h29, 8'h20, 8'h2a, 8'h5f, 8'h0e, 8'h00, 8'h2e, 8'h66, 8'h0a,
    8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // Size of one offset estimate step in hertz.
  localparam int OFFSET_STEP_HZ = 7800;

  typedef enum logic [2:0] {
    ST_HUNT = 3'b001,
    ST_SFDB = 3'b010,
    ST_LOCK = 3'b100
  } mst_sync_state_t;

  // One demodulated symbol with its correlation value.
  typedef struct packed {
    logic       valid;
    logic       zero;
    logic       sfd_a;
    logic       sfd_b;
    logic [4:0] corr;
  } mst_symbol_t;

  // Settings handed to the demodulator and modulator.
  typedef struct packed {
    logic [1:0] sync_zero_symbol_count;
    logic       offset_averaging_policy;
    logic       sfd_strict_correlation;
    logic [4:0] correlator_threshold;
    logic       frame_observer_enable;
    logic       phase_reversed;
  } mst_modem_cfg_t;

endpackage
`default_nettype wire

/* rtl/mst_regs.sv */
// Modem sync detection, offset estimate hold and tuning register bank on AXI4-Lite.
// Function
// - Strict bit 0 needs one zero symbol above threshold; 1 adds both SFD symbols.
// - Five-bit correlator threshold, reset 0x0E, must be exceeded before SFD search.
// - Carrier offset estimate reads back as read-only eight-bit two's complement.
// - Each estimate step stands for 7800 Hz.
// - Policy 0 updates the estimate until sync, then freezes it until frame end.
// - Policy 1 updates the estimate continuously while the demodulator is enabled.
// - Observer enable routes received and transmitted data to pins; resets clear.
// - Phase bit selects standard or reversed modulation for both directions; resets 0.
// - Two-bit setting asks one to three zero symbols; only one above threshold.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`default_nettype none
module mst_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  input  wire mst_pkg::mst_symbol_t  symbol,
  input  wire logic                  frame_end,
  input  wire logic                  demod_enable,
  input  wire logic                  offset_valid,
  input  wire logic [7:0]            offset_in,
  input  wire logic                  rx_data_bit,
  input  wire logic                  tx_data_bit,
  output logic                       sync_found,
  output mst_pkg::mst_modem_cfg_t    modem_cfg,
  output logic                       gpio_rx_observe,
  output logic                       gpio_tx_observe,
  output logic [7:0]                 tune_flat [mst_pkg::NUM_TUNE]
);
  import mst_pkg::*;

  logic [7:0]                 zero_avg_r;
  logic [7:0]                 sync_ctl_r;
  logic [7:0]                 offset_r;
  logic [7:0]                 obs_phase_r;
  logic [7:0]                 tune_r [NUM_TUNE];

  logic                       awready_r;
  logic                       wready_r;
  logic                       aw_held_r;
  logic                       w_held_r;
  logic [6:0]                 wr_idx_r;
  logic                       wr_idx_ok_r;
  logic [7:0]                 wr_byte_r;
  logic                       wr_lane_r;
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;
  logic                       arready_r;
  logic                       rvalid_r;
  logic [7:0]                 rdata_r;
  logic [1:0]                 rresp_r;

  logic                       wr_go;
  logic                       wr_en;
  logic [6:0]                 rd_idx;
  logic                       rd_idx_ok;
  logic [7:0]                 rd_byte;
  logic                       rd_hit;

  mst_sync_state_t            state_r;
  logic [1:0]                 zero_cnt_r;
  logic                       zero_above_r;
  logic                       sfd_a_above_r;
  logic                       sync_found_r;
  logic                       gpio_rx_r;
  logic                       gpio_tx_r;

  logic [1:0]                 zeros_needed;
  logic                       above;
  logic                       strict;
  logic                       avg_policy;
  logic                       observe_en;

  assign strict     = sync_ctl_r[POS_SFD_STRICT];
  assign avg_policy = zero_avg_r[POS_AVG_POLICY];
  assign observe_en = obs_phase_r[POS_OBSERVER_EN];
  assign above      = symbol.corr > sync_ctl_r[POS_CORRELATOR_THRESHOLD +: 5];
  // The reserved count code 00 behaves as one zero symbol so the detector never stalls.
  assign zeros_needed = (zero_avg_r[POS_ZERO_COUNT +: 2] == 2'b00) ?
                        2'b01 : zero_avg_r[POS_ZERO_COUNT +: 2];

  // Byte address is four times the register index; addresses beyond the index range miss.
  assign rd_idx    = s_axi_araddr[8:2];
  assign rd_idx_ok = (s_axi_araddr[ADDR_W-1:9] == '0) && (s_axi_araddr[1:0] == 2'b00);
  assign wr_go     = aw_held_r && w_held_r && !bvalid_r;
  assign wr_en     = wr_go && wr_idx_ok_r && wr_lane_r;

  // Read mux; reserved and unused bits come back as zero.
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b0;
    if (rd_idx_ok) begin
      case (rd_idx)
        IDX_ZERO_AVG_CONTROL: begin
          rd_byte = zero_avg_r & MSK_ZERO_AVG_CONTROL;
          rd_hit  = 1'b1;
        end
        IDX_SYNC_DETECT_CONTROL: begin
          rd_byte = sync_ctl_r & MSK_SYNC_DETECT_CONTROL;
          rd_hit  = 1'b1;
        end
        IDX_CARRIER_OFFSET: begin
          rd_byte = offset_r;
          rd_hit  = 1'b1;
        end
        IDX_OBSERVER_PHASE: begin
          rd_byte = obs_phase_r & MSK_OBSERVER_PHASE;
          rd_hit  = 1'b1;
        end
        IDX_UNUSED_SLOT: begin
          rd_byte = 8'h00;
          rd_hit  = 1'b1;
        end
        default: begin
          for (int i = 0; i < NUM_TUNE; i++) begin
            if (rd_idx == TUNE_IDX[i]) begin
              rd_byte = tune_r[i];
              rd_hit  = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Write address and write data are taken independently and joined before the update.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r   <= 1'b0;
      wready_r    <= 1'b0;
      aw_held_r   <= 1'b0;
      w_held_r    <= 1'b0;
      wr_idx_r    <= 7'h00;
      wr_idx_ok_r <= 1'b0;
      wr_byte_r   <= 8'h00;
      wr_lane_r   <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= RESP_OKAY;
    end else if (ce) begin
      if (!aw_held_r && !bvalid_r)
        awready_r <= !(s_axi_awvalid && awready_r);
      if (!w_held_r && !bvalid_r)
        wready_r <= !(s_axi_wvalid && wready_r);
      if (s_axi_awvalid && awready_r) begin
        aw_held_r   <= 1'b1;
        wr_idx_r    <= s_axi_awaddr[8:2];
        wr_idx_ok_r <= (s_axi_awaddr[ADDR_W-1:9] == '0) && (s_axi_awaddr[1:0] == 2'b00);
      end
      if (s_axi_wvalid && wready_r) begin
        w_held_r  <= 1'b1;
        wr_byte_r <= s_axi_wdata[7:0];
        wr_lane_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit(wr_idx_r, wr_idx_ok_r) ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  function automatic logic wr_hit(input logic [6:0] idx, input logic ok);
    logic hit;
    hit = ok && ((idx == IDX_ZERO_AVG_CONTROL) || (idx == IDX_SYNC_DETECT_CONTROL) ||
                 (idx == IDX_CARRIER_OFFSET) || (idx == IDX_OBSERVER_PHASE) ||
                 (idx == IDX_UNUSED_SLOT));
    for (int i = 0; i < NUM_TUNE; i++) begin
      if (ok && (idx == TUNE_IDX[i]))
        hit = 1'b1;
    end
    return hit;
  endfunction

  // Read channel: one read under way, data returned the cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 8'h00;
      rresp_r   <= RESP_OKAY;
    end else if (ce) begin
      if (!rvalid_r && !arready_r) begin
        arready_r <= 1'b1;
      end
      if (s_axi_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_byte;
        rresp_r   <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Control registers; writes to reserved read-only bits are dropped by the masks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_avg_r  <= RST_ZERO_AVG_CONTROL;
      sync_ctl_r  <= RST_SYNC_DETECT_CONTROL;
      obs_phase_r <= RST_OBSERVER_PHASE;
    end else if (ce && wr_en) begin
      case (wr_idx_r)
        IDX_ZERO_AVG_CONTROL:    zero_avg_r  <= wr_byte_r & MSK_ZERO_AVG_CONTROL;
        IDX_SYNC_DETECT_CONTROL: sync_ctl_r  <= wr_byte_r & MSK_SYNC_DETECT_CONTROL;
        IDX_OBSERVER_PHASE:      obs_phase_r <= wr_byte_r & MSK_OBSERVER_PHASE;
        default: begin
        end
      endcase
    end
  end

  // Tuning registers are plain storage handed out to the analog and test logic.
  for (genvar g = 0; g < NUM_TUNE; g++) begin : g_tune
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tune_r[g] <= TUNE_RST[g];
      end else if (ce && wr_en && (wr_idx_r == TUNE_IDX[g])) begin
        tune_r[g] <= wr_byte_r;
      end
    end
    assign tune_flat[g] = tune_r[g];
  end

  // Sync search: zero symbols, then the two SFD symbols.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r       <= ST_HUNT;
      zero_cnt_r    <= 2'b00;
      zero_above_r  <= 1'b0;
      sfd_a_above_r <= 1'b0;
      sync_found_r  <= 1'b0;
    end else if (ce) begin
      sync_found_r <= 1'b0;
      case (state_r)
        ST_HUNT: begin
          if (symbol.valid && symbol.zero) begin
            if (zero_cnt_r != 2'b11)
              zero_cnt_r <= zero_cnt_r + 2'b01;
            zero_above_r <= zero_above_r | above;
          end else if (symbol.valid && symbol.sfd_a && (zero_cnt_r >= zeros_needed) &&
                       zero_above_r) begin
            sfd_a_above_r <= above;
            state_r       <= ST_SFDB;
          end else if (symbol.valid) begin
            zero_cnt_r   <= 2'b00;
            zero_above_r <= 1'b0;
          end
        end
        ST_SFDB: begin
          if (symbol.valid) begin
            zero_cnt_r   <= 2'b00;
            zero_above_r <= 1'b0;
            // Strict mode also demands both SFD symbols above the threshold.
            if (symbol.sfd_b && (!strict || (sfd_a_above_r && above))) begin
              sync_found_r <= 1'b1;
              state_r      <= ST_LOCK;
            end else begin
              state_r <= ST_HUNT;
            end
          end
        end
        ST_LOCK: begin
          if (frame_end)
            state_r <= ST_HUNT;
        end
        default: begin
          state_r <= ST_HUNT;
        end
      endcase
      if (!demod_enable) begin
        state_r      <= ST_HUNT;
        zero_cnt_r   <= 2'b00;
        zero_above_r <= 1'b0;
      end
    end
  end

  // Offset estimate; under policy 0 the value found at sync stays put for the whole frame.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_r <= RST_CARRIER_OFFSET;
    end else if (ce && demod_enable && offset_valid) begin
      if (avg_policy) begin
        offset_r <= offset_in;
      end else if (state_r != ST_LOCK && !sync_found_r) begin
        offset_r <= offset_in;
      end
    end
  end

  // Observer taps are gated so the pins stay quiet while disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_rx_r <= 1'b0;
      gpio_tx_r <= 1'b0;
    end else if (ce) begin
      gpio_rx_r <= observe_en & rx_data_bit;
      gpio_tx_r <= observe_en & tx_data_bit;
    end
  end

  // One assignment drives the whole settings word so the output has a single driver.
  assign modem_cfg = '{
    sync_zero_symbol_count:  zero_avg_r[POS_ZERO_COUNT +: 2],
    offset_averaging_policy: avg_policy,
    sfd_strict_correlation:  strict,
    correlator_threshold:    sync_ctl_r[POS_CORRELATOR_THRESHOLD +: 5],
    frame_observer_enable:   observe_en,
    phase_reversed:          obs_phase_r[POS_PHASE_REV]
  };

  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rdata    = {24'h000000, rdata_r};
  assign s_axi_rresp    = rresp_r;
  assign sync_found     = sync_found_r;
  assign gpio_rx_observe = gpio_rx_r;
  assign gpio_tx_observe = gpio_tx_r;

endmodule
`default_nettype wire

/* verification/mst_regs_sva.sv */
// Concurrent checks on the ports of the modem sync and tuning register bank.
`default_nettype none
module mst_regs_chk (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    ce,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_bvalid,
  input wire mst_pkg::mst_symbol_t    symbol,
  input wire logic                    sync_found,
  input wire mst_pkg::mst_modem_cfg_t modem_cfg,
  input wire logic                    rx_data_bit,
  input wire logic                    tx_data_bit,
  input wire logic                    gpio_rx_observe,
  input wire logic                    gpio_tx_observe
);
  import mst_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  strict_corr_a: assert property (
    sync_found && $past(modem_cfg.sfd_strict_correlation)
    |-> $past(symbol.corr) > $past(modem_cfg.correlator_threshold))
    else $error("strict sync accepted a second sync symbol at or below threshold");
  sync_cause_a: assert property (
    sync_found |-> $past(symbol.valid && symbol.sfd_b && ce))
    else $error("sync reported without a second sync symbol just before");
  sync_gap_a: assert property (
    sync_found |=> !sync_found [*2])
    else $error("sync reported again too soon");
  rd_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read answer late");
  cfg_write_a: assert property (
    $changed(modem_cfg) |-> $rose(s_axi_bvalid))
    else $error("settings changed without a completed write");
  obs_rx_a: assert property (
    $past(ce) |-> gpio_rx_observe == $past(modem_cfg.frame_observer_enable && rx_data_bit))
    else $error("receive observer pin wrong");
  obs_tx_a: assert property (
    $past(ce) |-> gpio_tx_observe == $past(modem_cfg.frame_observer_enable && tx_data_bit))
    else $error("transmit observer pin wrong");

  cover property (sync_found && !modem_cfg.sfd_strict_correlation);
  cover property (sync_found && modem_cfg.sfd_strict_correlation);
  cover property (gpio_rx_observe);
endmodule

bind mst_regs mst_regs_chk u_chk (
  .aclk, .aresetn, .ce, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .s_axi_bvalid, .symbol, .sync_found, .modem_cfg, .rx_data_bit, .tx_data_bit,
  .gpio_rx_observe, .gpio_tx_observe
);
`default_nettype wire

/* verification/mst_demod_model.sv */
// Demodulator stand-in that feeds symbols, offset estimates and frame ends.
`default_nettype none
module mst_demod_model (
  input  wire logic                aclk,
  output var mst_pkg::mst_symbol_t symbol,
  output logic                     frame_end,
  output logic                     offset_valid,
  output logic [7:0]               offset_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import mst_pkg::*;

  initial begin
    symbol = '0;
    frame_end = 1'b0;
    offset_valid = 1'b0;
    offset_in = 8'h00;
  end

  // Idle cycles carry inverted flags so that a block that ignores valid is caught.
  task automatic sym(input logic z, input logic a, input logic b, input logic [4:0] c);
    symbol <= '{1'b1, z, a, b, c};
    @(posedge aclk);
    symbol <= '{1'b0, ~z, ~a, ~b, ~c};
    @(posedge aclk);
  endtask

  // The estimate is a signed count of fixed frequency steps.
  task automatic ofs(input logic [7:0] v);
    offset_valid <= 1'b1;
    offset_in <= v;
    @(posedge aclk);
    offset_valid <= 1'b0;
    offset_in <= ~v;
    @(posedge aclk);
  endtask

  task automatic fend();
    frame_end <= 1'b1;
    @(posedge aclk);
    frame_end <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* verification/mst_regs_test.sv */
// Self-checking bench for the modem sync and tuning register bank.
`default_nettype none
module mst_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mst_pkg::*;

  typedef struct packed {
    logic       w;
    logic [6:0] i;
    logic [7:0] d;
    logic [7:0] e;
    logic [1:0] r;
  } mst_row_t;

  logic           aclk = 1'b0;
  logic           aresetn = 1'b0;
  logic           ce = 1'b1;
  logic           s_axi_awvalid = 1'b0;
  logic           s_axi_wvalid = 1'b0;
  logic           s_axi_bready = 1'b0;
  logic           s_axi_arvalid = 1'b0;
  logic           s_axi_rready = 1'b0;
  logic [11:0]    s_axi_awaddr = 12'h000;
  logic [11:0]    s_axi_araddr = 12'h000;
  logic [31:0]    s_axi_wdata = 32'h0;
  logic [2:0]     prot = 3'h0;
  logic [3:0]     s_axi_wstrb = 4'hf;
  logic           demod_enable = 1'b0;
  logic           rx_data_bit = 1'b0;
  logic           tx_data_bit = 1'b0;
  logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]     s_axi_bresp, s_axi_rresp;
  logic [31:0]    s_axi_rdata;
  logic           sync_found, gpio_rx_observe, gpio_tx_observe, frame_end, offset_valid;
  logic [7:0]     offset_in;
  mst_symbol_t    symbol;
  mst_modem_cfg_t modem_cfg;
  logic [7:0]     tune_flat [NUM_TUNE];
  int             num_errors = 0, checks = 0, nsync = 0, cyc = 0;

  mst_row_t rows [14] = '{
    '{1'b0, 7'h47, 8'h00, 8'h2e, RESP_OKAY},
    '{1'b0, 7'h48, 8'h00, 8'h00, RESP_OKAY},
    '{1'b0, 7'h5b, 8'h00, 8'h08, RESP_OKAY},
    '{1'b0, 7'h46, 8'h00, 8'h40, RESP_OKAY},
    '{1'b1, 7'h47, 8'hff, 8'h00, RESP_OKAY},
    '{1'b0, 7'h47, 8'h00, 8'h3f, RESP_OKAY},
    '{1'b1, 7'h5b, 8'hfe, 8'h00, RESP_OKAY},
    '{1'b0, 7'h5b, 8'h00, 8'h0e, RESP_OKAY},
    '{1'b1, 7'h62, 8'hff, 8'h00, RESP_OKAY},
    '{1'b0, 7'h62, 8'h00, 8'h00, RESP_OKAY},
    '{1'b0, 7'h49, 8'h00, 8'h00, RESP_DECERR},
    '{1'b1, 7'h4b, 8'h01, 8'h00, RESP_DECERR},
    '{1'b1, 7'h4a, 8'h5a, 8'h00, RESP_OKAY},
    '{1'b0, 7'h4a, 8'h00, 8'h5a, RESP_OKAY}};

  mst_regs dut (
    .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(prot), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(prot), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .symbol, .frame_end, .demod_enable, .offset_valid, .offset_in,
    .rx_data_bit, .tx_data_bit, .sync_found, .modem_cfg, .gpio_rx_observe,
    .gpio_tx_observe, .tune_flat
  );
  mst_demod_model u_dm (.aclk, .symbol, .frame_end, .offset_valid, .offset_in);

  always #50 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (sync_found === 1'b1) nsync <= nsync + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] i, input logic [7:0] d, output logic [1:0] r);
    logic a;
    logic w;
    @(posedge aclk);
    a = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {3'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (a || w) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      a = a && s_axi_awready !== 1'b1;
      w = w && s_axi_wready !== 1'b1;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {3'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic acc(input logic w, input logic [6:0] i, input logic [7:0] d,
                     input logic [7:0] e, input logic [1:0] r);
    logic [31:0] q;
    logic [1:0]  s;
    if (w) wr(i, d, s);
    else rd(i, q, s);
    if (!w) chk(q, {24'h0, e});
    chk({30'h0, s}, {30'h0, r});
  endtask

  // Zero symbols, then both sync symbols; the fixed wait covers the one-cycle sync pulse.
  task automatic frame(input int nz, input logic [4:0] zc, input logic [4:0] ac,
                       input logic [4:0] bc, input logic fe, input int exp);
    int n0;
    n0 = nsync;
    repeat (nz) u_dm.sym(1'b1, 1'b0, 1'b0, zc);
    u_dm.sym(1'b0, 1'b1, 1'b0, ac);
    u_dm.sym(1'b0, 1'b0, 1'b1, bc);
    repeat (3) @(posedge aclk);
    chk(32'(nsync - n0), 32'(exp));
    if (fe) u_dm.fend();
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    demod_enable <= 1'b1;
    for (int k = 0; k < NUM_TUNE; k++) acc(1'b0, TUNE_IDX[k], 8'h00, TUNE_RST[k], RESP_OKAY);
    for (int k = 0; k < 14; k++) acc(rows[k].w, rows[k].i, rows[k].d, rows[k].e, rows[k].r);
    chk(32'(tune_flat[0]), 32'h5a);
    $display("register table done");
    rx_data_bit <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(32'(gpio_rx_observe), 32'h1);
    chk(32'(gpio_tx_observe), 32'h0);
    chk(32'(modem_cfg.phase_reversed), 32'h1);
    rx_data_bit <= 1'b0;
    tx_data_bit <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(32'(gpio_rx_observe), 32'h0);
    chk(32'(gpio_tx_observe), 32'h1);
    acc(1'b1, IDX_OBSERVER_PHASE, 8'h08, 8'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(gpio_tx_observe), 32'h0);
    chk(32'(modem_cfg.phase_reversed), 32'h0);
    $display("observer and phase done");
    acc(1'b1, IDX_SYNC_DETECT_CONTROL, 8'h14, 8'h00, RESP_OKAY);
    frame(1, 5'h15, 5'h00, 5'h00, 1'b1, 1);
    frame(1, 5'h14, 5'h1f, 5'h1f, 1'b1, 0);
    acc(1'b1, IDX_SYNC_DETECT_CONTROL, 8'h34, 8'h00, RESP_OKAY);
    frame(1, 5'h15, 5'h15, 5'h14, 1'b1, 0);
    frame(1, 5'h15, 5'h15, 5'h15, 1'b1, 1);
    acc(1'b1, IDX_ZERO_AVG_CONTROL, 8'hc0, 8'h00, RESP_OKAY);
    demod_enable <= 1'b0;
    @(posedge aclk);
    demod_enable <= 1'b1;
    frame(2, 5'h15, 5'h15, 5'h15, 1'b1, 0);
    frame(3, 5'h15, 5'h15, 5'h15, 1'b1, 1);
    $display("sync detection done");
    acc(1'b1, IDX_ZERO_AVG_CONTROL, 8'h40, 8'h00, RESP_OKAY);
    u_dm.ofs(8'h80);
    acc(1'b0, IDX_CARRIER_OFFSET, 8'h00, 8'h80, RESP_OKAY);
    frame(1, 5'h15, 5'h15, 5'h15, 1'b0, 1);
    u_dm.ofs(8'h05);
    acc(1'b0, IDX_CARRIER_OFFSET, 8'h00, 8'h80, RESP_OKAY);
    u_dm.fend();
    u_dm.ofs(8'h7f);
    acc(1'b0, IDX_CARRIER_OFFSET, 8'h00, 8'h7f, RESP_OKAY);
    acc(1'b1, IDX_ZERO_AVG_CONTROL, 8'h60, 8'h00, RESP_OKAY);
    frame(1, 5'h15, 5'h15, 5'h15, 1'b0, 1);
    u_dm.ofs(8'h33);
    acc(1'b1, IDX_CARRIER_OFFSET, 8'hff, 8'h00, RESP_OKAY);
    acc(1'b0, IDX_CARRIER_OFFSET, 8'h00, 8'h33, RESP_OKAY);
    // With the clock enable low a fresh estimate must not land.
    ce <= 1'b0;
    u_dm.ofs(8'h44);
    ce <= 1'b1;
    acc(1'b0, IDX_CARRIER_OFFSET, 8'h00, 8'h33, RESP_OKAY);
    $display("offset estimate done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    acc(1'b0, IDX_SYNC_DETECT_CONTROL, 8'h00, 8'h2e, RESP_OKAY);
    acc(1'b0, IDX_OBSERVER_PHASE, 8'h00, 8'h08, RESP_OKAY);
    acc(1'b0, IDX_ZERO_AVG_CONTROL, 8'h00, 8'h40, RESP_OKAY);
    $display("second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
